//--- rtl/dlsu_pkg.sv
// Shared constants and carrier types for the direct I/O load/store descriptor unit.
package dlsu_pkg;
   // Configuration bus geometry.
   localparam int          CFG_AW         = 12;
   localparam int          SETS           = 4;
   localparam logic [11:0] SET1_BASE      = 12'h400;
   localparam logic [11:0] SET2_BASE      = 12'h420;
   localparam logic [11:0] SET3_BASE      = 12'h440;
   localparam logic [11:0] SET4_BASE      = 12'h460;
   localparam int          SET_SEL_LSB    = 5;
   localparam int          WORD_SEL_LSB   = 2;
   // Word offsets inside one descriptor set.
   localparam logic [4:0]  OFS_EXT_ADDR   = 5'h00;
   localparam logic [4:0]  OFS_REM_ADDR   = 5'h04;
   localparam logic [4:0]  OFS_LOCAL_ADDR = 5'h08;
   localparam logic [4:0]  OFS_LENGTH     = 5'h0C;
   localparam logic [4:0]  OFS_CONTROL    = 5'h10;
   localparam logic [4:0]  OFS_COMMAND    = 5'h14;
   localparam logic [4:0]  OFS_STATUS     = 5'h18;
   // Control word fields.
   localparam int          CTL_PORT_LSB   = 30;
   localparam int          CTL_PRIO_LSB   = 28;
   localparam int          CTL_XAMSB_LSB  = 26;
   localparam int          CTL_IDW_LSB    = 24;
   localparam int          CTL_DEST_LSB   = 8;
   localparam int          CTL_IRQ_BIT    = 0;
   // Command word fields.
   localparam int          CMD_INFO_LSB   = 16;
   localparam int          CMD_HOP_LSB    = 8;
   localparam int          CMD_TYPE_LSB   = 0;
   // Status word fields.
   localparam int          STS_BUSY_BIT   = 31;
   localparam int          LEN_W          = 12;
   // Reset values.
   localparam logic [31:0] RST_WORD       = 32'h0000_0000;
   localparam logic [7:0]  RST_TID        = 8'h00;
   // Packet types that the unit can build.
   localparam logic [3:0]  FT_NREAD       = 4'h2;
   localparam logic [3:0]  FT_ATOMIC      = 4'h5;
   localparam logic [3:0]  FT_SWRITE      = 4'h6;
   localparam logic [3:0]  FT_MAINT       = 4'h8;
   localparam logic [3:0]  FT_DOORBELL    = 4'hA;
   localparam logic [12:0] MAINT_MAX_LEN  = 13'h0004;
   localparam logic [12:0] FULL_LEN       = 13'h1000;
   // Completion codes.
   typedef enum logic [2:0] {
      CC_OK       = 3'h0,
      CC_TIMEOUT  = 3'h1,
      CC_XOFF     = 3'h2,
      CC_ERR_RESP = 3'h3,
      CC_INVALID  = 3'h4,
      CC_DMA_ERR  = 3'h5,
      CC_RETRY    = 3'h6,
      CC_NO_CRED  = 3'h7
   } dlsu_code_e;
   // Request handed to the packet builder and payload mover.
   typedef struct packed {
      logic [1:0]  set;
      logic [1:0]  port;
      logic [3:0]  ftype;
      logic [3:0]  ttype;
      logic [1:0]  tt;
      logic [1:0]  prio;
      logic [1:0]  xamsbs;
      logic [15:0] dest_id;
      logic [31:0] ext_addr;
      logic [28:0] dword_addr;
      logic [3:0]  size;
      logic        wdptr;
      logic [7:0]  tid;
      logic [7:0]  hop;
      logic [15:0] info;
      logic [31:0] local_addr;
      logic [12:0] length;
   } dlsu_req_s;
   // Completion report from the transport side.
   typedef struct packed {
      logic [1:0]  set;
      dlsu_code_e  code;
   } dlsu_done_s;
endpackage : dlsu_pkg

//--- rtl/dlsu_unit.sv
// Direct I/O load/store descriptor unit: four descriptor sets and the request launcher.
//
// Behaviour
// - Writing a set's command word launches one request; other words start nothing.
// - Hardware generates the transaction identifier for every request.
// - Four descriptor sets decode at 400h, 420h, 440h, 460h, words up to +18h.
// - Types 2, 5, 6 carry the 32-bit extended address word in the header.
// - Types 2, 5, 6 combine remote address and length into a doubleword-aligned address.
// - Maintenance uses a 24-bit config offset whose two low bits must be zero.
// - Local byte address only steers the payload, never appears in a header.
// - Length codes 1 to 4095 bytes, zero means 4K; it derives size and word pointer.
// - Device ID width drives tt: 00b 8-bit, 01b 16-bit, others reserved.
// - Priority field copies to prio, 0 lowest and 3 highest.
// - Extended address MSB field copies to the header xamsbs field.
// - Target node identifier copies to the header destination ID.
// - Upper four bits of packet type give the ftype of every packet.
// - Receiving side takes the header address and moves payload by DMA.
// - Lower four bits of packet type give ttype for types 2, 5 and 8.
// - Busy reads 1 during a transfer, 0 when writable; code valid when idle.
// - Completion codes 000b to 111b report success or the failure cause.
// - Interrupt request bit set raises an interrupt at completion, clear raises none.
`timescale 1ns/10ps
module dlsu_unit
(
   input  wire logic                 core_clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic                 cfg_valid_i,
   input  wire logic                 cfg_write_i,
   input  wire logic [11:0]          cfg_addr_i,
   input  wire logic [31:0]          cfg_wdata_i,
   output logic                      cfg_ready_o,
   output logic                      cfg_rvalid_o,
   output logic [31:0]               cfg_rdata_o,
   output logic                      req_valid_o,
   input  wire logic                 req_ready_i,
   output dlsu_pkg::dlsu_req_s       req_o,
   input  wire logic                 done_valid_i,
   input  wire dlsu_pkg::dlsu_done_s done_i,
   output logic [3:0]                irq_o,
   output logic [3:0]                busy_o
);
   localparam int N = dlsu_pkg::SETS;

   // Descriptor storage, one element per set.
   logic [31:0] ext_addr   [N];
   logic [31:0] rem_addr   [N];
   logic [31:0] local_addr [N];
   logic [11:0] len_code   [N];
   logic [31:0] control    [N];
   logic [31:0] command    [N];
   logic [2:0]  code       [N];
   logic [N-1:0] busy;
   logic [N-1:0] pend;
   logic [N-1:0] finish;
   logic [2:0]   finish_code [N];
   logic [N-1:0] set_hit;
   logic         in_window;
   logic [1:0]   set_idx;
   logic [4:0]   word_ofs;
   logic [1:0]   rr_ptr;
   logic [1:0]   sel;
   logic         found;
   logic         launch;
   logic         sel_bad;
   logic [7:0]   tid;
   logic [12:0]  sel_len;
   logic [3:0]   sel_type;
   dlsu_pkg::dlsu_req_s next_req;

   // Decode the four sets; the upper bits must land in the 400h..47Fh window.
   assign in_window   = (cfg_addr_i[11:7] == dlsu_pkg::SET1_BASE[11:7]);
   assign set_idx     = cfg_addr_i[6:dlsu_pkg::SET_SEL_LSB];
   assign word_ofs    = cfg_addr_i[4:0];
   assign cfg_ready_o = 1'b1;
   assign busy_o      = busy;

   // Translate a length code and a byte offset into a size code and word pointer.
   function automatic logic [4:0] size_code(input logic [12:0] len, input logic [2:0] ofs);
      logic [4:0] r;
      r = {1'b1, 4'hF};
      if (len == 13'h0001)
         r = {ofs[2], 2'b00, ofs[1:0]};
      else if (len == 13'h0002)
         r = {ofs[2], ofs[1] ? 4'h6 : 4'h4};
      else if (len <= 13'h0004)
         r = {ofs[2], 4'h8};
      else if (len <= 13'h0008)
         r = {1'b0, 4'hB};
      else if (len <= 13'h0010)
         r = {1'b1, 4'hB};
      else if (len <= 13'h0020)
         r = {1'b0, 4'hC};
      else if (len <= 13'h0040)
         r = {1'b1, 4'hC};
      else if (len <= 13'h0080)
         r = {1'b1, 4'hD};
      return r;
   endfunction : size_code

   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : g_set
         logic wr_hit;
         assign set_hit[g] = in_window && (set_idx == 2'(g));
         // Descriptors are locked while the set is busy so a transfer never sees them change.
         assign wr_hit = cfg_valid_i && cfg_write_i && set_hit[g] && !busy[g];

         // Descriptor word writes.
         always_ff @(posedge core_clk_i)
         begin
            if (!rst_n_i)
            begin
               ext_addr[g]   <= dlsu_pkg::RST_WORD;
               rem_addr[g]   <= dlsu_pkg::RST_WORD;
               local_addr[g] <= dlsu_pkg::RST_WORD;
               len_code[g]   <= dlsu_pkg::RST_WORD[11:0];
               control[g]    <= dlsu_pkg::RST_WORD;
               command[g]    <= dlsu_pkg::RST_WORD;
            end
            else if (wr_hit)
            begin
               unique case (word_ofs)
                  dlsu_pkg::OFS_EXT_ADDR:   ext_addr[g]   <= cfg_wdata_i;
                  dlsu_pkg::OFS_REM_ADDR:   rem_addr[g]   <= cfg_wdata_i;
                  dlsu_pkg::OFS_LOCAL_ADDR: local_addr[g] <= cfg_wdata_i;
                  dlsu_pkg::OFS_LENGTH:     len_code[g]   <= cfg_wdata_i[dlsu_pkg::LEN_W-1:0];
                  dlsu_pkg::OFS_CONTROL:    control[g]    <= cfg_wdata_i;
                  dlsu_pkg::OFS_COMMAND:    command[g]    <= cfg_wdata_i;
                  default:                  ext_addr[g]   <= ext_addr[g];
               endcase
            end
         end

         // A finish comes from the transport for this set, or from a refused launch.
         always_comb
         begin
            finish[g]      = 1'b0;
            finish_code[g] = dlsu_pkg::CC_OK;
            if (launch && sel_bad && (sel == 2'(g)))
            begin
               finish[g]      = 1'b1;
               finish_code[g] = dlsu_pkg::CC_INVALID;
            end
            else if (done_valid_i && (done_i.set == 2'(g)) && busy[g] && !pend[g])
            begin
               finish[g]      = 1'b1;
               finish_code[g] = done_i.code;
            end
         end

         // Busy, pending and completion code per set.
         always_ff @(posedge core_clk_i)
         begin
            if (!rst_n_i)
            begin
               busy[g] <= 1'b0;
               pend[g] <= 1'b0;
               code[g] <= dlsu_pkg::CC_OK;
            end
            else if (wr_hit && (word_ofs == dlsu_pkg::OFS_COMMAND))
            begin
               busy[g] <= 1'b1;
               pend[g] <= 1'b1;
            end
            else
            begin
               if (launch && (sel == 2'(g)))
                  pend[g] <= 1'b0;
               if (finish[g])
               begin
                  busy[g] <= 1'b0;
                  code[g] <= finish_code[g];
               end
            end
         end

         // Completion interrupt, only when software asked for one.
         always_ff @(posedge core_clk_i)
         begin
            if (!rst_n_i)
               irq_o[g] <= 1'b0;
            else
               irq_o[g] <= finish[g] && control[g][dlsu_pkg::CTL_IRQ_BIT];
         end
      end
   endgenerate

   // Round-robin pick among pending sets so one busy set cannot starve the others.
   always_comb
   begin
      logic [1:0] idx;
      idx   = 2'b00;
      sel   = 2'b00;
      found = 1'b0;
      for (int i = 0; i < N; i++)
      begin
         idx = rr_ptr + 2'(i);
         if (pend[idx] && !found)
         begin
            sel   = idx;
            found = 1'b1;
         end
      end
   end

   assign launch   = found && (!req_valid_o || req_ready_i);
   assign sel_type = command[sel][dlsu_pkg::CMD_TYPE_LSB+4 +: 4];
   // A zero length code stands for a full 4K transfer.
   assign sel_len  = (len_code[sel] == 12'h000) ? dlsu_pkg::FULL_LEN : {1'b0, len_code[sel]};

   // Programming checks; a bad descriptor completes at once without a packet.
   always_comb
   begin
      sel_bad = 1'b0;
      if (control[sel][dlsu_pkg::CTL_IDW_LSB+1])
         sel_bad = 1'b1;
      if (!(sel_type inside {dlsu_pkg::FT_NREAD, dlsu_pkg::FT_ATOMIC, dlsu_pkg::FT_SWRITE,
                             dlsu_pkg::FT_MAINT, dlsu_pkg::FT_DOORBELL}))
         sel_bad = 1'b1;
      if ((sel_type == dlsu_pkg::FT_MAINT) &&
          ((sel_len > dlsu_pkg::MAINT_MAX_LEN) || (rem_addr[sel][1:0] != 2'b00)))
         sel_bad = 1'b1;
   end

   // Map the selected descriptor onto the request header fields.
   always_comb
   begin
      logic [4:0] sz;
      sz                  = size_code(sel_len, rem_addr[sel][2:0]);
      next_req            = '0;
      next_req.set        = sel;
      next_req.port       = control[sel][dlsu_pkg::CTL_PORT_LSB +: 2];
      next_req.ftype      = sel_type;
      next_req.tt         = control[sel][dlsu_pkg::CTL_IDW_LSB +: 2];
      next_req.prio       = control[sel][dlsu_pkg::CTL_PRIO_LSB +: 2];
      next_req.xamsbs     = control[sel][dlsu_pkg::CTL_XAMSB_LSB +: 2];
      next_req.dest_id    = control[sel][dlsu_pkg::CTL_DEST_LSB +: 16];
      next_req.size       = sz[3:0];
      next_req.wdptr      = sz[4];
      next_req.tid        = tid;
      next_req.hop        = command[sel][dlsu_pkg::CMD_HOP_LSB +: 8];
      next_req.info       = command[sel][dlsu_pkg::CMD_INFO_LSB +: 16];
      next_req.local_addr = local_addr[sel];
      next_req.length     = sel_len;
      if (sel_type inside {dlsu_pkg::FT_NREAD, dlsu_pkg::FT_ATOMIC, dlsu_pkg::FT_MAINT})
         next_req.ttype = command[sel][dlsu_pkg::CMD_TYPE_LSB +: 4];
      if (sel_type == dlsu_pkg::FT_MAINT)
         next_req.dword_addr = {8'h00, rem_addr[sel][23:3]};
      else
         next_req.dword_addr = rem_addr[sel][31:3];
      if (sel_type inside {dlsu_pkg::FT_NREAD, dlsu_pkg::FT_ATOMIC, dlsu_pkg::FT_SWRITE})
         next_req.ext_addr = ext_addr[sel];
   end

   // Request output stage; it holds until the packet builder takes it.
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         req_valid_o <= 1'b0;
         req_o       <= '0;
      end
      else if (launch && !sel_bad)
      begin
         req_valid_o <= 1'b1;
         req_o       <= next_req;
      end
      else if (req_ready_i)
         req_valid_o <= 1'b0;
   end

   // Arbitration pointer advances on every launch; the transaction identifier only on launches that send a request.
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         tid    <= dlsu_pkg::RST_TID;
         rr_ptr <= 2'b00;
      end
      else if (launch)
      begin
         rr_ptr <= sel + 2'b01;
         if (!sel_bad)
            tid <= tid + 8'h01;
      end
   end

   // Registered read path; unmapped words and addresses read as zero.
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         cfg_rvalid_o <= 1'b0;
         cfg_rdata_o  <= dlsu_pkg::RST_WORD;
      end
      else
      begin
         cfg_rvalid_o <= cfg_valid_i && !cfg_write_i;
         cfg_rdata_o  <= dlsu_pkg::RST_WORD;
         if (cfg_valid_i && !cfg_write_i && in_window)
         begin
            unique case (word_ofs)
               dlsu_pkg::OFS_EXT_ADDR:   cfg_rdata_o <= ext_addr[set_idx];
               dlsu_pkg::OFS_REM_ADDR:   cfg_rdata_o <= rem_addr[set_idx];
               dlsu_pkg::OFS_LOCAL_ADDR: cfg_rdata_o <= local_addr[set_idx];
               dlsu_pkg::OFS_LENGTH:     cfg_rdata_o <= {20'h00000, len_code[set_idx]};
               dlsu_pkg::OFS_CONTROL:    cfg_rdata_o <= control[set_idx];
               dlsu_pkg::OFS_COMMAND:    cfg_rdata_o <= command[set_idx];
               dlsu_pkg::OFS_STATUS:     cfg_rdata_o <= {busy[set_idx], 28'h0000000, code[set_idx]};
               default:                  cfg_rdata_o <= dlsu_pkg::RST_WORD;
            endcase
         end
      end
   end
endmodule : dlsu_unit

//--- sim/dlsu_unit_sva.sv
// Concurrent checks on the ports of the load/store descriptor unit.
`timescale 1ns/10ps
module dlsu_unit_sva
(
   input  wire logic                 core_clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic                 cfg_valid_i,
   input  wire logic                 cfg_write_i,
   input  wire logic [11:0]          cfg_addr_i,
   input  wire logic [31:0]          cfg_wdata_i,
   input  wire logic                 cfg_ready_o,
   input  wire logic                 cfg_rvalid_o,
   input  wire logic [31:0]          cfg_rdata_o,
   input  wire logic                 req_valid_o,
   input  wire logic                 req_ready_i,
   input  wire dlsu_pkg::dlsu_req_s  req_o,
   input  wire logic                 done_valid_i,
   input  wire dlsu_pkg::dlsu_done_s done_i,
   input  wire logic [3:0]           irq_o,
   input  wire logic [3:0]           busy_o
);
   logic [7:0] last_tid;
   logic       tid_seen;
   wire logic  req_take = req_valid_o && req_ready_i;
   wire logic  set_hit  = cfg_valid_i && cfg_write_i && cfg_addr_i[11:7] == 5'h08;
   // The first accepted request has no predecessor, so the identifier check waits for one.
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
         tid_seen <= 1'b0;
      else if (req_take)
      begin
         tid_seen <= 1'b1;
         last_tid <= req_o.tid;
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   AST_CMD_LAUNCH: assert property (set_hit && cfg_addr_i[4:0] == 5'h14 && !busy_o[cfg_addr_i[6:5]]
      |=> busy_o[$past(cfg_addr_i[6:5])]) else $error("command write did not mark the set busy");
   AST_WORD_NO_START: assert property (cfg_valid_i && cfg_write_i && cfg_addr_i[4:0] != 5'h14
      |=> (busy_o & ~$past(busy_o)) == 4'h0) else $error("descriptor word write started a set");
   AST_UNMAPPED_ZERO: assert property (cfg_valid_i && !cfg_write_i && cfg_addr_i[11:7] != 5'h08
      |=> cfg_rvalid_o && cfg_rdata_o == 32'h0) else $error("unmapped read gave data");
   AST_REQ_HOLD: assert property (req_valid_o && !req_ready_i |=> req_valid_o && $stable(req_o))
      else $error("request changed before it was taken");
   AST_FTYPE_TT: assert property (req_valid_o |-> req_o.ftype inside {4'h2, 4'h5, 4'h6, 4'h8, 4'hA}
      && !req_o.tt[1]) else $error("illegal ftype or tt in request");
   AST_TTYPE_ZERO: assert property (req_valid_o && !(req_o.ftype inside {4'h2, 4'h5, 4'h8})
      |-> req_o.ttype == 4'h0) else $error("ttype set for a type without one");
   AST_EXT_ZERO: assert property (req_valid_o && !(req_o.ftype inside {4'h2, 4'h5, 4'h6})
      |-> req_o.ext_addr == 32'h0) else $error("extended address on wrong type");
   AST_TID_STEP: assert property (req_take && tid_seen |-> req_o.tid == last_tid + 8'h01)
      else $error("transaction identifier did not advance");
   AST_IRQ_AT_END: assert property (|irq_o |-> (irq_o & ~$past(busy_o)) == 4'h0 && (irq_o & busy_o) == 4'h0)
      else $error("interrupt outside completion");
   AST_MAINT_OFS: assert property (req_valid_o && req_o.ftype == 4'h8
      |-> req_o.dword_addr[28:21] == 8'h00 && req_o.length <= 13'h0004) else $error("bad maintenance request");
   // Main traffic kinds seen by the run.
   cover property (req_take);
   cover property (|irq_o);
   cover property (done_valid_i && done_i.code != dlsu_pkg::CC_OK);
endmodule : dlsu_unit_sva

//--- sim/dlsu_far_model.sv
// Packet builder and remote element model that takes requests and reports completions.
`timescale 1ns/10ps
module dlsu_far_model
(
   input  wire logic                 core_clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic                 slow_i,
   input  wire dlsu_pkg::dlsu_code_e code_i,
   input  wire logic                 req_valid_i,
   input  wire dlsu_pkg::dlsu_req_s  req_i,
   output logic                      req_ready_o = 1'b0,
   output logic                      done_valid_o = 1'b0,
   output dlsu_pkg::dlsu_done_s      done_o = '0
);
   logic [3:0]  wait_cnt = 4'h0;
   logic        owed = 1'b0;
   logic        pace = 1'b0;
   logic [1:0]  owed_set;
   logic [31:0] target_addr;
   // One transaction at a time; the slow mode stalls both acceptance and the answer.
   always @(posedge core_clk_i)
   begin
      pace <= ~pace;
      if (rst_n_i && owed && wait_cnt == 4'h0)
      begin
         owed         <= 1'b0;
         done_valid_o <= 1'b1;
         done_o       <= {owed_set, code_i};
      end
      else
      begin
         // Each output is written once per edge; the set field is meaningless outside the pulse.
         done_valid_o <= 1'b0;
         done_o.set   <= ~done_o.set;
         if (!rst_n_i)
         begin
            owed        <= 1'b0;
            req_ready_o <= 1'b0;
         end
         else if (req_valid_i && req_ready_o)
         begin
            owed        <= 1'b1;
            owed_set    <= req_i.set;
            req_ready_o <= 1'b0;
            target_addr <= {req_i.dword_addr, 3'h0};
            wait_cnt    <= slow_i ? 4'hF : 4'h2;
         end
         else if (owed)
            wait_cnt <= wait_cnt - 4'h1;
         else
            req_ready_o <= !slow_i || pace;
      end
   end
endmodule : dlsu_far_model

//--- sim/dlsu_unit_tb.sv
// Self-checking bench for the load/store descriptor unit.
`timescale 1ns/10ps
module dlsu_unit_tb;
   logic                 core_clk_i = 1'b0;
   logic                 rst_n_i = 1'b0;
   logic                 cfg_valid_i = 1'b0;
   logic                 cfg_write_i = 1'b0;
   logic [11:0]          cfg_addr_i = 12'h000;
   logic [31:0]          cfg_wdata_i = 32'h0;
   logic                 cfg_ready_o;
   logic                 cfg_rvalid_o;
   logic [31:0]          cfg_rdata_o;
   logic                 req_valid_o;
   logic                 req_ready_i;
   dlsu_pkg::dlsu_req_s  req_o;
   logic                 done_valid_i;
   dlsu_pkg::dlsu_done_s done_i;
   logic [3:0]           irq_o;
   logic [3:0]           busy_o;
   logic                 slow = 1'b0;
   dlsu_pkg::dlsu_code_e code = dlsu_pkg::CC_OK;
   int                   bad_count = 0;
   int                   comparisons = 0;
   logic [31:0]          rd;
   logic [7:0]           tid0;
   dlsu_pkg::dlsu_req_s  got;
   // Clock at 50 MHz.
   always #10 core_clk_i = ~core_clk_i;
   dlsu_unit dlsu_unit_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cfg_valid_i(cfg_valid_i),
      .cfg_write_i(cfg_write_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_ready_o(cfg_ready_o),
      .cfg_rvalid_o(cfg_rvalid_o), .cfg_rdata_o(cfg_rdata_o), .req_valid_o(req_valid_o), .req_ready_i(req_ready_i),
      .req_o(req_o), .done_valid_i(done_valid_i), .done_i(done_i), .irq_o(irq_o), .busy_o(busy_o));
   dlsu_far_model dlsu_far_model_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .slow_i(slow), .code_i(code),
      .req_valid_i(req_valid_o), .req_i(req_o), .req_ready_o(req_ready_i), .done_valid_o(done_valid_i),
      .done_o(done_i));
   task automatic stop_test;
      if (bad_count == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // Writes leave the strobe up so that consecutive writes go back to back.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      cfg_valid_i <= 1'b1;
      cfg_write_i <= 1'b1;
      cfg_addr_i <= a;
      cfg_wdata_i <= d;
   endtask : wr
   task automatic idle;
      @(posedge core_clk_i);
      cfg_valid_i <= 1'b0;
   endtask : idle
   task automatic rd_reg(input logic [11:0] a);
      @(posedge core_clk_i);
      cfg_valid_i <= 1'b1;
      cfg_write_i <= 1'b0;
      cfg_addr_i <= a;
      idle();
      #1;
      chk("rvalid", cfg_rvalid_o, 1'b1);
      rd = cfg_rdata_o;
   endtask : rd_reg
   // Fills one descriptor set; no word before the command may start the set.
   task automatic prog(input logic [1:0] s, input logic [31:0] ctl, input logic [31:0] cmd, input logic [31:0] rem,
                       input logic [31:0] len);
      logic [11:0] b;
      b = {5'h08, s, 5'h00};
      wr(b, 32'h1234_5678);
      wr(b + 12'h004, rem);
      wr(b + 12'h008, 32'hA000_0010);
      wr(b + 12'h00C, len);
      wr(b + 12'h010, ctl);
      idle();
      #1;
      chk("busy_before_cmd", busy_o[s], 1'b0);
      wr(b + 12'h014, cmd);
      idle();
      // Step off the edge so callers see busy settled, not the old value; the request comes out a cycle later.
      #1;
   endtask : prog
   task automatic wait_req;
      int n;
      for (n = 0; n < 60 && req_valid_o !== 1'b1; n++)
         @(posedge core_clk_i) #1;
      if (n == 60)
      begin
         bad_count++;
         stop_test();
      end
      got = req_o;
   endtask : wait_req
   task automatic wait_idle(input logic [1:0] s, input logic irq);
      int n;
      for (n = 0; n < 100 && busy_o[s] !== 1'b0; n++)
         @(posedge core_clk_i) #1;
      if (n == 100)
      begin
         bad_count++;
         stop_test();
      end
      chk("irq", irq_o[s], irq);
   endtask : wait_idle
   // Main sequence.
   initial
   begin
      repeat (8) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      #1;
      chk("busy_rst", busy_o, 4'h0);
      chk("ready", cfg_ready_o, 1'b1);
      rd_reg(12'h47C);
      chk("gap_word", rd, 32'h0);
      rd_reg(12'h3FC);
      chk("below_sets", rd, 32'h0);
      prog(2'd0, 32'h79BE_EF01, 32'h0000_0024, 32'h0000_1008, 32'h8);
      #1;
      chk("busy_cmd", busy_o[0], 1'b1);
      wait_req();
      tid0 = got.tid;
      chk("ftype", got.ftype, 4'h2);
      chk("ttype", got.ttype, 4'h4);
      chk("tt", got.tt, 2'b01);
      chk("prio", got.prio, 2'h3);
      chk("xamsbs", got.xamsbs, 2'h2);
      chk("dest", got.dest_id, 16'hBEEF);
      chk("ext", got.ext_addr, 32'h1234_5678);
      chk("dword", got.dword_addr, 29'h201);
      chk("size", {got.size, got.wdptr}, 5'h16);
      chk("local", got.local_addr, 32'hA000_0010);
      chk("port_set", {got.port, got.set}, 4'h4);
      wait_idle(2'd0, 1'b1);
      rd_reg(12'h418);
      chk("status", rd, 32'h0);
      prog(2'd1, 32'h0000_1200, 32'h0000_0060, 32'h0000_2000, 32'h0);
      wait_req();
      chk("tid", got.tid, tid0 + 8'h01);
      chk("sw_type", {got.ftype, got.ttype, got.tt}, 10'h180);
      chk("len4k", got.length, 13'h1000);
      chk("size4k", {got.size, got.wdptr}, 5'h1F);
      wait_idle(2'd1, 1'b0);
      code <= dlsu_pkg::CC_ERR_RESP;
      prog(2'd2, 32'h0000_3401, 32'h0000_0580, 32'h0000_0104, 32'h4);
      wait_req();
      chk("maint", {got.ftype, got.hop}, 12'h805);
      chk("maint_ext", got.ext_addr, 32'h0);
      chk("cfg_ofs", got.dword_addr, 29'h20);
      wait_idle(2'd2, 1'b1);
      rd_reg(12'h458);
      chk("err_code", rd[2:0], 3'h3);
      prog(2'd3, 32'h0000_3400, 32'h0000_0080, 32'h0000_0102, 32'h4);
      wait_idle(2'd3, 1'b0);
      rd_reg(12'h478);
      chk("bad_ofs", rd[2:0], 3'h4);
      prog(2'd3, 32'h0200_3400, 32'h0000_0024, 32'h0000_1008, 32'h8);
      wait_idle(2'd3, 1'b0);
      rd_reg(12'h478);
      chk("bad_idw", rd[2:0], 3'h4);
      for (int k = 0; k < 8; k++)
      begin
         code <= dlsu_pkg::dlsu_code_e'(k);
         prog(2'd0, 32'h0000_1200, 32'h5A5A_00A0, 32'h0000_0008, 32'h8);
         wait_req();
         chk("doorbell", {got.ftype, got.ttype, got.info}, 24'hA0_5A5A);
         wait_idle(2'd0, 1'b0);
         rd_reg(12'h418);
         chk("code", rd, {29'h0, k[2:0]});
      end
      slow <= 1'b1;
      prog(2'd0, 32'h0000_1201, 32'h0000_0024, 32'h0000_0008, 32'h8);
      prog(2'd1, 32'h0000_1200, 32'h0000_0060, 32'h0000_0010, 32'h10);
      chk("both_busy", busy_o, 4'h3);
      wait_idle(2'd0, 1'b1);
      chk("other_busy", busy_o[1], 1'b1);
      wait_idle(2'd1, 1'b0);
      stop_test();
   end
endmodule : dlsu_unit_tb
bind dlsu_unit dlsu_unit_sva dlsu_unit_sva_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
   .cfg_valid_i(cfg_valid_i), .cfg_write_i(cfg_write_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
   .cfg_ready_o(cfg_ready_o), .cfg_rvalid_o(cfg_rvalid_o), .cfg_rdata_o(cfg_rdata_o), .req_valid_o(req_valid_o),
   .req_ready_i(req_ready_i), .req_o(req_o), .done_valid_i(done_valid_i), .done_i(done_i), .irq_o(irq_o),
   .busy_o(busy_o));
